/* File: hdl/exec_subset_pkg.sv */
// Package: types and constants shared by the instruction subset execution unit
package exec_subset_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int PROG_ADDR_W = 12;
    localparam int PROG_W = 15;
    localparam int PAGE_W = 4;
    localparam int TBL_HIGH_W = PROG_W - DATA_W;

    // ****************************************************************
    // Reset values and constants
    // ****************************************************************
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [TBL_HIGH_W-1:0] TBL_HIGH_RESET = 7'h00;
    localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hF;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;

    // ****************************************************************
    // Operation codes
    // ****************************************************************
    typedef enum logic [4:0] {
        OP_NONE                   = 5'h00,
        OP_INCR_SKIP_NULL         = 5'h01,
        OP_INCR_TO_ACC_SKIP_NULL  = 5'h02,
        OP_SKIP_BIT_SET           = 5'h03,
        OP_SKIP_BIT_CLEAR         = 5'h04,
        OP_SKIP_IF_NULL           = 5'h05,
        OP_COPY_SKIP_IF_NULL      = 5'h06,
        OP_MINUS_TO_ACC           = 5'h07,
        OP_MINUS_TO_MEMORY        = 5'h08,
        OP_MINUS_IMM_TO_ACC       = 5'h09,
        OP_MINUS_CARRY_TO_ACC     = 5'h0A,
        OP_MINUS_CARRY_TO_MEMORY  = 5'h0B,
        OP_NIBBLE_EXCHANGE        = 5'h0C,
        OP_NIBBLE_EXCHANGE_TO_ACC = 5'h0D,
        OP_TABLE_READ_CURRENT     = 5'h0E,
        OP_TABLE_READ_LAST        = 5'h0F,
        OP_XOR_TO_ACC             = 5'h10,
        OP_XOR_TO_MEMORY          = 5'h11,
        OP_XOR_IMM_TO_ACC         = 5'h12
    } op_t;

    typedef enum logic [0:0] {
        ST_IDLE      = 1'b0,
        ST_TBL_FETCH = 1'b1
    } state_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        op_t op;
        logic [2:0] bit_sel;
        logic [ADDR_W-1:0] mem_addr;
        logic [DATA_W-1:0] mem_data;
        logic [DATA_W-1:0] imm;
    } exec_req_t;

    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mem_wr_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } flags_t;

    localparam flags_t FLAGS_RESET = 4'h0;
    localparam mem_wr_t MEM_WR_IDLE = 17'h00000;

endpackage : exec_subset_pkg

/* File: hdl/minus_flags_unit.sv */
// Module: 8-bit subtractor with borrow-inverse input and flag outputs
`timescale 1ns/1ps
`default_nettype none

module minus_flags_unit
    import exec_subset_pkg::*;
(
    // Operands
    input wire logic [DATA_W-1:0] minuend,
    input wire logic [DATA_W-1:0] subtrahend,
    input wire logic borrow_inv_in,
    // Result
    output logic [DATA_W-1:0] diff,
    output exec_subset_pkg::flags_t flags
);
    logic [DATA_W:0] wide;
    logic [4:0] low_nib;
    logic not_c;

    always_comb
    begin
        not_c = ~borrow_inv_in;
        wide = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, not_c};
        low_nib = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, not_c};
        diff = wide[DATA_W-1:0];
        // Borrow out of bit 8 means a negative result, so the carry reads 0
        flags.c = ~wide[DATA_W];
        flags.ac = ~low_nib[4];
        flags.z = (wide[DATA_W-1:0] == BYTE_ZERO);
        flags.ov = (minuend[7] != subtrahend[7]) && (wide[7] != minuend[7]);
    end

endmodule : minus_flags_unit
`default_nettype wire

/* File: hdl/byte_ops_unit.sv */
// Module: increment, nibble exchange, exclusive OR and bit/zero tests of a byte
`timescale 1ns/1ps
`default_nettype none

module byte_ops_unit
    import exec_subset_pkg::*;
(
    // Operands
    input wire logic [DATA_W-1:0] mem_byte,
    input wire logic [DATA_W-1:0] other_byte,
    input wire logic [2:0] bit_sel,
    // Results
    output logic [DATA_W-1:0] incr,
    output logic [DATA_W-1:0] swapped,
    output logic [DATA_W-1:0] xored,
    output logic incr_null,
    output logic mem_null,
    output logic xor_null,
    output logic sel_bit
);
    always_comb
    begin
        incr = mem_byte + BYTE_ONE;
        swapped = {mem_byte[3:0], mem_byte[7:4]};
        xored = other_byte ^ mem_byte;
        incr_null = (incr == BYTE_ZERO);
        mem_null = (mem_byte == BYTE_ZERO);
        xor_null = (xored == BYTE_ZERO);
        sel_bit = mem_byte[bit_sel];
    end

endmodule : byte_ops_unit
`default_nettype wire

/* File: hdl/instr_exec_subset.sv */
// Module: execution unit for the skip, subtract, swap, table read and XOR instructions
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none

module instr_exec_subset
    import exec_subset_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Instruction request from fetch and decode
    input wire logic exec_valid,
    input wire exec_subset_pkg::exec_req_t exec_req,
    output logic exec_ready,
    output logic exec_done,
    // Program counter and table pointer
    input wire logic [PROG_ADDR_W-1:0] pc,
    input wire logic [DATA_W-1:0] table_pointer,
    output logic skip_next,
    // Program memory port for table reads
    output logic prog_rd,
    output logic [PROG_ADDR_W-1:0] prog_addr,
    input wire logic [PROG_W-1:0] prog_data,
    // Data memory write port
    output exec_subset_pkg::mem_wr_t mem_wr,
    // Accumulator load by instructions outside this subset
    input wire logic acc_load,
    input wire logic [DATA_W-1:0] acc_load_data,
    // Architectural state
    output logic [DATA_W-1:0] acc,
    output exec_subset_pkg::flags_t flags,
    output logic [TBL_HIGH_W-1:0] table_high_latch
);
    import exec_subset_pkg::*;

    // ****************************************************************
    // Registers
    // ****************************************************************
    state_t state_q;
    state_t state_d;
    logic [DATA_W-1:0] acc_q;
    flags_t flags_q;
    logic [TBL_HIGH_W-1:0] tbl_high_q;
    mem_wr_t mem_wr_q;
    logic skip_q;
    logic done_q;
    logic prog_rd_q;
    logic [PROG_ADDR_W-1:0] prog_addr_q;
    logic [ADDR_W-1:0] tbl_dest_q;

    // ****************************************************************
    // Datapath
    // ****************************************************************
    logic take;
    logic [DATA_W-1:0] sub_rhs;
    logic sub_cin;
    logic [DATA_W-1:0] sub_diff;
    flags_t sub_flags;
    logic [DATA_W-1:0] xor_rhs;
    logic [DATA_W-1:0] incr;
    logic [DATA_W-1:0] swapped;
    logic [DATA_W-1:0] xored;
    logic incr_null;
    logic mem_null;
    logic xor_null;
    logic sel_bit;

    assign take = exec_valid && (state_q == ST_IDLE);
    assign exec_ready = (state_q == ST_IDLE);

    always_comb
    begin
        sub_rhs = exec_req.mem_data;
        sub_cin = 1'b1;
        xor_rhs = exec_req.mem_data;
        case (exec_req.op)
            OP_MINUS_IMM_TO_ACC: sub_rhs = exec_req.imm;
            OP_MINUS_CARRY_TO_ACC,
            OP_MINUS_CARRY_TO_MEMORY: sub_cin = flags_q.c;
            OP_XOR_IMM_TO_ACC: xor_rhs = exec_req.imm;
            default: sub_cin = 1'b1;
        endcase
    end

    minus_flags_unit u_minus (
        .minuend(acc_q),
        .subtrahend(sub_rhs),
        .borrow_inv_in(sub_cin),
        .diff(sub_diff),
        .flags(sub_flags)
    );

    byte_ops_unit u_byte_ops (
        .mem_byte(exec_req.mem_data),
        .other_byte(acc_q),
        .bit_sel(exec_req.bit_sel),
        .incr(incr),
        .swapped(swapped),
        .xored(xored),
        .incr_null(incr_null),
        .mem_null(mem_null),
        .xor_null(xor_null),
        .sel_bit(sel_bit)
    );

    // XOR with immediate needs its own result since the byte unit sees memory
    logic [DATA_W-1:0] xor_res;
    logic xor_res_null;
    always_comb
    begin
        xor_res = (exec_req.op == OP_XOR_IMM_TO_ACC) ? (acc_q ^ xor_rhs) : xored;
        xor_res_null = (exec_req.op == OP_XOR_IMM_TO_ACC) ? ((acc_q ^ xor_rhs) == BYTE_ZERO)
                                                           : xor_null;
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (take && (exec_req.op == OP_TABLE_READ_CURRENT ||
                             exec_req.op == OP_TABLE_READ_LAST))
                begin
                    state_d = ST_TBL_FETCH;
                end
            end
            ST_TBL_FETCH: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // Program memory access for table reads
    // ****************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            prog_rd_q <= 1'b0;
            prog_addr_q <= '0;
            tbl_dest_q <= '0;
        end
        else if (take && exec_req.op == OP_TABLE_READ_CURRENT)
        begin
            prog_rd_q <= 1'b1;
            prog_addr_q <= {pc[PROG_ADDR_W-1:DATA_W], table_pointer};
            tbl_dest_q <= exec_req.mem_addr;
        end
        else if (take && exec_req.op == OP_TABLE_READ_LAST)
        begin
            prog_rd_q <= 1'b1;
            prog_addr_q <= {LAST_PAGE, table_pointer};
            tbl_dest_q <= exec_req.mem_addr;
        end
        else
        begin
            prog_rd_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            tbl_high_q <= TBL_HIGH_RESET;
        end
        else if (state_q == ST_TBL_FETCH)
        begin
            tbl_high_q <= prog_data[PROG_W-1:DATA_W];
        end
    end

    // ****************************************************************
    // Accumulator
    // ****************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            acc_q <= ACC_RESET;
        end
        else if (take)
        begin
            case (exec_req.op)
                OP_INCR_TO_ACC_SKIP_NULL: acc_q <= incr;
                OP_COPY_SKIP_IF_NULL: acc_q <= exec_req.mem_data;
                OP_MINUS_TO_ACC,
                OP_MINUS_IMM_TO_ACC,
                OP_MINUS_CARRY_TO_ACC: acc_q <= sub_diff;
                OP_NIBBLE_EXCHANGE_TO_ACC: acc_q <= swapped;
                OP_XOR_TO_ACC,
                OP_XOR_IMM_TO_ACC: acc_q <= xor_res;
                default: acc_q <= acc_q;
            endcase
        end
        else if (acc_load && state_q == ST_IDLE)
        begin
            acc_q <= acc_load_data;
        end
    end

    // ****************************************************************
    // Flags
    // ****************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            flags_q <= FLAGS_RESET;
        end
        else if (take)
        begin
            case (exec_req.op)
                OP_MINUS_TO_ACC,
                OP_MINUS_TO_MEMORY,
                OP_MINUS_IMM_TO_ACC,
                OP_MINUS_CARRY_TO_ACC,
                OP_MINUS_CARRY_TO_MEMORY: flags_q <= sub_flags;
                OP_XOR_TO_ACC,
                OP_XOR_TO_MEMORY,
                OP_XOR_IMM_TO_ACC: flags_q.z <= xor_res_null;
                default: flags_q <= flags_q;
            endcase
        end
    end

    // ****************************************************************
    // Data memory write-back
    // ****************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            mem_wr_q <= MEM_WR_IDLE;
        end
        else if (state_q == ST_TBL_FETCH)
        begin
            mem_wr_q.en <= 1'b1;
            mem_wr_q.addr <= tbl_dest_q;
            mem_wr_q.data <= prog_data[DATA_W-1:0];
        end
        else if (take)
        begin
            mem_wr_q.addr <= exec_req.mem_addr;
            case (exec_req.op)
                OP_INCR_SKIP_NULL:
                begin
                    mem_wr_q.en <= 1'b1;
                    mem_wr_q.data <= incr;
                end
                OP_MINUS_TO_MEMORY,
                OP_MINUS_CARRY_TO_MEMORY:
                begin
                    mem_wr_q.en <= 1'b1;
                    mem_wr_q.data <= sub_diff;
                end
                OP_NIBBLE_EXCHANGE:
                begin
                    mem_wr_q.en <= 1'b1;
                    mem_wr_q.data <= swapped;
                end
                OP_XOR_TO_MEMORY:
                begin
                    mem_wr_q.en <= 1'b1;
                    mem_wr_q.data <= xored;
                end
                default: mem_wr_q.en <= 1'b0;
            endcase
        end
        else
        begin
            mem_wr_q.en <= 1'b0;
        end
    end

    // ****************************************************************
    // Skip decision and completion
    // ****************************************************************
    // The fetch unit turns the next fetched word into a dummy on this pulse
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            skip_q <= 1'b0;
        end
        else if (take)
        begin
            case (exec_req.op)
                OP_INCR_SKIP_NULL,
                OP_INCR_TO_ACC_SKIP_NULL: skip_q <= incr_null;
                OP_SKIP_BIT_SET: skip_q <= sel_bit;
                OP_SKIP_BIT_CLEAR: skip_q <= ~sel_bit;
                OP_SKIP_IF_NULL,
                OP_COPY_SKIP_IF_NULL: skip_q <= mem_null;
                default: skip_q <= 1'b0;
            endcase
        end
        else
        begin
            skip_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            done_q <= 1'b0;
        end
        else
        begin
            // Table reads finish one cycle later than everything else
            done_q <= (take && state_d == ST_IDLE && exec_req.op != OP_NONE) ||
                      (state_q == ST_TBL_FETCH);
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign exec_done = done_q;
    assign skip_next = skip_q;
    assign prog_rd = prog_rd_q;
    assign prog_addr = prog_addr_q;
    assign mem_wr = mem_wr_q;
    assign acc = acc_q;
    assign flags = flags_q;
    assign table_high_latch = tbl_high_q;

endmodule : instr_exec_subset
`default_nettype wire

/* File: verif/exec_subset_properties.sv */
// Checker: timing and result properties of the instruction subset execution unit
`timescale 1ns/1ps
`default_nettype none

module exec_subset_checker
    import exec_subset_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Request side
    input wire logic exec_valid,
    input wire exec_subset_pkg::exec_req_t exec_req,
    input wire logic exec_ready,
    input wire logic exec_done,
    input wire logic [PROG_ADDR_W-1:0] pc,
    input wire logic [DATA_W-1:0] table_pointer,
    input wire logic skip_next,
    // Memories
    input wire logic prog_rd,
    input wire logic [PROG_ADDR_W-1:0] prog_addr,
    input wire logic [PROG_W-1:0] prog_data,
    input wire exec_subset_pkg::mem_wr_t mem_wr,
    // State
    input wire logic acc_load,
    input wire logic [DATA_W-1:0] acc_load_data,
    input wire logic [DATA_W-1:0] acc,
    input wire exec_subset_pkg::flags_t flags,
    input wire logic [TBL_HIGH_W-1:0] table_high_latch
);
    // ********
    // Helper logic
    // ********
    logic take, take_q, cin, ov, z, ac, c, c_q;
    exec_req_t req_q;
    logic [DATA_W-1:0] acc_q, rhs, xr, swp, tp_q;
    logic [PROG_ADDR_W-1:0] pc_q, tbl_addr;
    logic [PROG_W-1:0] pd_q;
    logic [8:0] full;
    logic [4:0] nib;
    assign take = reset_n && exec_valid && exec_ready;
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            take_q <= 1'h0;
        else
            take_q <= take;
    end
    // Operands are frozen at the take so later traffic cannot disturb the expectation
    always_ff @(posedge sys_clk)
    begin
        if (take)
        begin
            req_q <= exec_req;
            acc_q <= acc;
            c_q <= flags.c;
            pc_q <= pc;
            tp_q <= table_pointer;
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (prog_rd)
            pd_q <= prog_data;
    end
    assign rhs = (req_q.op inside {OP_MINUS_IMM_TO_ACC, OP_XOR_IMM_TO_ACC}) ? req_q.imm
        : req_q.mem_data;
    assign cin = (req_q.op inside {OP_MINUS_CARRY_TO_ACC, OP_MINUS_CARRY_TO_MEMORY}) ? c_q : 1'h1;
    assign full = {1'h0, acc_q} - {1'h0, rhs} - {8'h00, ~cin};
    assign nib = {1'h0, acc_q[3:0]} - {1'h0, rhs[3:0]} - {4'h0, ~cin};
    assign ov = (acc_q[7] != rhs[7]) && (full[7] != acc_q[7]);
    assign z = full[7:0] == 8'h00;
    assign ac = ~nib[4];
    assign c = ~full[8];
    assign xr = acc_q ^ rhs;
    assign swp = {req_q.mem_data[3:0], req_q.mem_data[7:4]};
    assign tbl_addr = {(req_q.op == OP_TABLE_READ_LAST) ? LAST_PAGE : pc_q[11:8], tp_q};

    // ********
    // Properties
    // ********
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_incr_mem: assert property (
        take_q && req_q.op == OP_INCR_SKIP_NULL |-> mem_wr.en && $stable(flags)
        && mem_wr.data == req_q.mem_data + 8'h01 && skip_next == (req_q.mem_data == 8'hFF))
        else $error("increment to memory wrong");
    a_incr_acc: assert property (
        take_q && req_q.op == OP_INCR_TO_ACC_SKIP_NULL |-> !mem_wr.en
        && acc == req_q.mem_data + 8'h01 && skip_next == (req_q.mem_data == 8'hFF))
        else $error("increment to acc wrong");
    a_skip_cause: assert property (
        skip_next |-> take_q && req_q.op inside {[OP_INCR_SKIP_NULL:OP_COPY_SKIP_IF_NULL]})
        else $error("skip without a skipping instruction");
    a_bit_skips: assert property (
        take_q && req_q.op inside {OP_SKIP_BIT_SET, OP_SKIP_BIT_CLEAR} |-> !mem_wr.en
        && $stable(flags)
        && skip_next == (req_q.mem_data[req_q.bit_sel] == (req_q.op == OP_SKIP_BIT_SET)))
        else $error("bit test skip wrong");
    a_null_skips: assert property (
        take_q && req_q.op inside {OP_SKIP_IF_NULL, OP_COPY_SKIP_IF_NULL} |-> !mem_wr.en
        && $stable(flags) && skip_next == (req_q.mem_data == 8'h00)
        && acc == ((req_q.op == OP_COPY_SKIP_IF_NULL) ? req_q.mem_data : acc_q))
        else $error("zero test skip wrong");
    a_minus_acc: assert property (
        take_q && req_q.op inside {OP_MINUS_TO_ACC, OP_MINUS_IMM_TO_ACC, OP_MINUS_CARRY_TO_ACC}
        |-> !mem_wr.en && acc == full[7:0] && flags == {ov, z, ac, c})
        else $error("subtract to acc wrong");
    a_minus_mem: assert property (
        take_q && req_q.op inside {OP_MINUS_TO_MEMORY, OP_MINUS_CARRY_TO_MEMORY}
        |-> mem_wr.en && mem_wr.data == full[7:0] && acc == acc_q && flags == {ov, z, ac, c})
        else $error("subtract to memory wrong");
    a_swap_mem: assert property (
        take_q && req_q.op == OP_NIBBLE_EXCHANGE |-> mem_wr.en && mem_wr.data == swp
        && mem_wr.addr == req_q.mem_addr && $stable(flags))
        else $error("nibble exchange to memory wrong");
    a_swap_acc: assert property (
        take_q && req_q.op == OP_NIBBLE_EXCHANGE_TO_ACC |-> !mem_wr.en && acc == swp
        && $stable(flags))
        else $error("nibble exchange to acc wrong");
    a_xor_acc: assert property (
        take_q && req_q.op inside {OP_XOR_TO_ACC, OP_XOR_IMM_TO_ACC} |-> acc == xr
        && flags.z == (xr == 8'h00) && $stable({flags.ov, flags.ac, flags.c}))
        else $error("xor to acc wrong");
    a_xor_mem: assert property (
        take_q && req_q.op == OP_XOR_TO_MEMORY |-> mem_wr.en && mem_wr.data == xr
        && acc == acc_q && flags.z == (xr == 8'h00) && $stable({flags.ov, flags.ac, flags.c}))
        else $error("xor to memory wrong");
    a_table_addr: assert property (
        take_q && req_q.op inside {OP_TABLE_READ_CURRENT, OP_TABLE_READ_LAST}
        |-> prog_rd && !exec_done && prog_addr == tbl_addr)
        else $error("table read address wrong");
    a_table_data: assert property (
        prog_rd |=> exec_done && mem_wr.en && mem_wr.addr == req_q.mem_addr
        && mem_wr.data == pd_q[7:0] && table_high_latch == pd_q[14:8] && $stable(flags))
        else $error("table read data wrong");
    a_done_single: assert property (
        take_q && req_q.op != OP_NONE
        && !(req_q.op inside {OP_TABLE_READ_CURRENT, OP_TABLE_READ_LAST}) |-> exec_done)
        else $error("instruction not done in one cycle");
endmodule : exec_subset_checker

bind instr_exec_subset exec_subset_checker chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .exec_valid(exec_valid), .exec_req(exec_req),
    .exec_ready(exec_ready), .exec_done(exec_done), .pc(pc), .table_pointer(table_pointer),
    .skip_next(skip_next), .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_data(prog_data),
    .mem_wr(mem_wr), .acc_load(acc_load), .acc_load_data(acc_load_data), .acc(acc),
    .flags(flags), .table_high_latch(table_high_latch)
);

`default_nettype wire

/* File: verif/mcu_side_model.sv */
// Partner model: data memory and program memory beside the execution unit
`timescale 1ns/1ps
`default_nettype none

module mcu_side_model
    import exec_subset_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Data memory
    input wire exec_subset_pkg::mem_wr_t mem_wr,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data,
    // Program memory
    input wire logic prog_rd,
    input wire logic [PROG_ADDR_W-1:0] prog_addr,
    output logic [PROG_W-1:0] prog_data
);
    logic [DATA_W-1:0] mem_q [0:255];
    logic [PROG_W-1:0] word;
    // Each location starts out holding its own address
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem_q[i] = i[7:0];
    end
    always @(posedge sys_clk)
    begin
        if (mem_wr.en)
            mem_q[mem_wr.addr] <= mem_wr.data;
    end
    assign rd_data = mem_q[rd_addr];
    assign word = {prog_addr[11:8], prog_addr[2:0], prog_addr[7:0] ^ 8'hA5};
    // Outside a read the bus shows the inverse word, so a late sample is caught
    assign prog_data = prog_rd ? word : ~word;
endmodule : mcu_side_model

`default_nettype wire

/* File: verif/mcu_instr_exec_subset_test.sv */
// Testbench: instruction sequences with expected results for the execution unit
`timescale 1ns/1ps
`default_nettype none

module mcu_instr_exec_subset_test;
    import exec_subset_pkg::*;
    logic sys_clk, reset_n, exec_valid, exec_ready, exec_done, skip_next, prog_rd, acc_load;
    exec_req_t exec_req;
    logic [PROG_ADDR_W-1:0] pc, prog_addr;
    logic [DATA_W-1:0] table_pointer, acc_load_data, acc, rd_addr, rd_data;
    logic [PROG_W-1:0] prog_data;
    mem_wr_t mem_wr;
    flags_t flags;
    logic [TBL_HIGH_W-1:0] table_high_latch;
    int errors, n_compared;

    instr_exec_subset dut (.sys_clk(sys_clk), .reset_n(reset_n), .exec_valid(exec_valid),
        .exec_req(exec_req), .exec_ready(exec_ready), .exec_done(exec_done), .pc(pc),
        .table_pointer(table_pointer), .skip_next(skip_next), .prog_rd(prog_rd),
        .prog_addr(prog_addr), .prog_data(prog_data), .mem_wr(mem_wr), .acc_load(acc_load),
        .acc_load_data(acc_load_data), .acc(acc), .flags(flags),
        .table_high_latch(table_high_latch));
    mcu_side_model side (.sys_clk(sys_clk), .mem_wr(mem_wr), .rd_addr(rd_addr),
        .rd_data(rd_data), .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_data(prog_data));

    // ********
    // Tasks
    // ********
    task automatic conclude;
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic load_acc(input logic [7:0] v);
        @(posedge sys_clk);
        acc_load <= 1'h1;
        acc_load_data <= v;
        @(posedge sys_clk);
        acc_load <= 1'h0;
        #1 check(acc, v);
    endtask : load_acc

    // Table reads answer one edge later than the rest
    task automatic run(input op_t op, input logic [7:0] addr, input logic [2:0] bsel,
        input logic [7:0] imm, input logic [7:0] e_acc, input logic [3:0] e_flags,
        input logic e_skip);
        rd_addr = addr;
        @(posedge sys_clk);
        exec_valid <= 1'h1;
        exec_req <= '{op, bsel, addr, rd_data, imm};
        @(posedge sys_clk);
        exec_valid <= 1'h0;
        if (op inside {OP_TABLE_READ_CURRENT, OP_TABLE_READ_LAST})
            @(posedge sys_clk);
        #1;
        check(exec_done, 1'h1);
        check(acc, e_acc);
        check(flags, e_flags);
        check(skip_next, e_skip);
    endtask : run

    task automatic mem_is(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge sys_clk) rd_addr <= addr;
        #1 check(rd_data, exp);
    endtask : mem_is

    // ********
    // Sequence
    // ********
    initial
    begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (2000) @(posedge sys_clk);
        errors++;
        conclude();
    end

    initial
    begin
        errors = 0;
        n_compared = 0;
        reset_n = 1'h0;
        exec_valid = 1'h0;
        exec_req = '0;
        pc = 12'h3A0;
        table_pointer = 8'h47;
        acc_load = 1'h0;
        acc_load_data = 8'h00;
        rd_addr = 8'h00;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'h1;
        #1 check({acc, flags, exec_ready}, {8'h00, 4'h0, 1'h1});
        load_acc(8'h50);
        run(OP_XOR_IMM_TO_ACC, 8'h00, 3'h0, 8'h50, 8'h00, 4'h4, 1'h0);
        run(OP_SKIP_IF_NULL, 8'h00, 3'h0, 8'h00, 8'h00, 4'h4, 1'h1);
        run(OP_INCR_SKIP_NULL, 8'hFF, 3'h0, 8'h00, 8'h00, 4'h4, 1'h1);
        run(OP_INCR_TO_ACC_SKIP_NULL, 8'hFE, 3'h0, 8'h00, 8'hFF, 4'h4, 1'h0);
        run(OP_COPY_SKIP_IF_NULL, 8'hFF, 3'h0, 8'h00, 8'h00, 4'h4, 1'h1);
        run(OP_SKIP_BIT_SET, 8'h04, 3'h2, 8'h00, 8'h00, 4'h4, 1'h1);
        run(OP_SKIP_BIT_SET, 8'h04, 3'h0, 8'h00, 8'h00, 4'h4, 1'h0);
        run(OP_SKIP_BIT_CLEAR, 8'h04, 3'h0, 8'h00, 8'h00, 4'h4, 1'h1);
        run(OP_SKIP_BIT_CLEAR, 8'h04, 3'h2, 8'h00, 8'h00, 4'h4, 1'h0);
        load_acc(8'h10);
        run(OP_MINUS_TO_ACC, 8'h20, 3'h0, 8'h00, 8'hF0, 4'h2, 1'h0);
        run(OP_MINUS_CARRY_TO_ACC, 8'h01, 3'h0, 8'h00, 8'hEE, 4'h1, 1'h0);
        run(OP_MINUS_IMM_TO_ACC, 8'h00, 3'h0, 8'hEE, 8'h00, 4'h7, 1'h0);
        load_acc(8'h80);
        run(OP_MINUS_TO_MEMORY, 8'h01, 3'h0, 8'h00, 8'h80, 4'h9, 1'h0);
        run(OP_MINUS_CARRY_TO_MEMORY, 8'h02, 3'h0, 8'h00, 8'h80, 4'h9, 1'h0);
        run(OP_NIBBLE_EXCHANGE, 8'h3C, 3'h0, 8'h00, 8'h80, 4'h9, 1'h0);
        run(OP_NIBBLE_EXCHANGE_TO_ACC, 8'h5A, 3'h0, 8'h00, 8'hA5, 4'h9, 1'h0);
        run(OP_XOR_TO_ACC, 8'hA5, 3'h0, 8'h00, 8'h00, 4'hD, 1'h0);
        load_acc(8'h0F);
        run(OP_XOR_TO_MEMORY, 8'h33, 3'h0, 8'h00, 8'h0F, 4'h9, 1'h0);
        run(OP_TABLE_READ_CURRENT, 8'h60, 3'h0, 8'h00, 8'h0F, 4'h9, 1'h0);
        check(table_high_latch, 7'h1F);
        run(OP_TABLE_READ_LAST, 8'h61, 3'h0, 8'h00, 8'h0F, 4'h9, 1'h0);
        check(table_high_latch, 7'h7F);
        mem_is(8'hFF, 8'h00);
        mem_is(8'hFE, 8'hFE);
        mem_is(8'h01, 8'h7F);
        mem_is(8'h02, 8'h7E);
        mem_is(8'h3C, 8'hC3);
        mem_is(8'h5A, 8'h5A);
        mem_is(8'h33, 8'h3C);
        mem_is(8'h60, 8'hE2);
        mem_is(8'h61, 8'hE2);
        conclude();
    end
endmodule : mcu_instr_exec_subset_test

`default_nettype wire
